// [rtl/ptcs_pkg.sv]
package ptcs_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CLK_SEL = 8'h09;
    localparam logic [7:0] IDX_TIMER_CTRL = 8'h0B;
    localparam logic [7:0] IDX_STATUS = 8'h10;
    localparam logic [7:0] IDX_COUNT = 8'h11;

    // Reset values
    localparam logic [7:0] CLK_SEL_RESET = 8'h00;
    localparam logic [7:0] TIMER_CTRL_RESET = 8'h00;

    // Clock source select field positions
    localparam int CS_PSEUDO_STOP_BIT = 6;
    localparam int CS_WD_SEL_HIGH_BIT = 4;
    localparam int CS_TIMER_SEL_BIT = 1;
    localparam int CS_WD_SEL_LOW_BIT = 0;

    // Timer control field positions
    localparam int TC_DECIMAL_BIT = 7;
    localparam int TC_PRESCALE_MSB = 6;
    localparam int TC_PRESCALE_LSB = 4;
    localparam int TC_MODULUS_MSB = 3;

    // Status field positions
    localparam int ST_OSC_UP_BIT = 0;
    localparam int ST_FLAG_BIT = 1;
    localparam int ST_RUNNING_BIT = 2;
    localparam int ST_TIMER_SEL_BIT = 3;

    // Prescaler figures
    localparam int PRESCALE_W = 18;
    localparam int BIN_SHIFT_BASE = 9;
    localparam logic [2:0] PRESCALE_OFF_CODE = 3'h0;
    localparam logic [PRESCALE_W-1:0] DEC_BASE_0 = 18'h0_03E8;
    localparam logic [PRESCALE_W-1:0] DEC_BASE_1 = 18'h0_07D0;
    localparam logic [PRESCALE_W-1:0] DEC_BASE_2 = 18'h0_1388;
    localparam logic [PRESCALE_W-1:0] DEC_BASE_3 = 18'h0_2710;
    localparam logic [PRESCALE_W-1:0] DEC_BASE_4 = 18'h0_4E20;
    localparam logic [PRESCALE_W-1:0] DEC_BASE_5 = 18'h0_C350;
    localparam logic [PRESCALE_W-1:0] DEC_BASE_6 = 18'h1_86A0;
    localparam logic [PRESCALE_W-1:0] DEC_BASE_7 = 18'h3_0D40;

    // Watchdog source codes
    localparam logic [1:0] WD_SRC_RC = 2'h0;
    localparam logic [1:0] WD_SRC_CRYSTAL = 2'h1;
    localparam logic [1:0] WD_SRC_ALWAYS_ON = 2'h2;

    // Clock enables of the three sources, one pclk cycle each
    typedef struct packed {
        logic always_on;
        logic crystal;
        logic trimmed_rc;
    } ptcs_ticks_t;

    // Timer control register layout
    typedef struct packed {
        logic decimal_divider_select;
        logic [2:0] prescale;
        logic [3:0] modulus;
    } ptcs_ctrl_t;

endpackage

// [rtl/ptcs_top.sv]
// Local design decision: register access over APB.
`timescale 1ns/1ps
// Function
// - Timer clock select bit: 0 picks trimmed RC clock, 1 picks crystal clock.
// - Changing the timer clock select bit restarts the timer period.
// - Timer clock select accepts 1 only while oscillator is up.
// - Oscillator loss clears the timer clock select bit.
// - Watchdog mux: 00 RC, 01 crystal, high bit 1 always-on RC.
// - With high watchdog bit 1, low bit changes do nothing.
// - With high watchdog bit 0, low bit change restarts watchdog period.
// - Low watchdog select accepts 1 only while oscillator is up.
// - Oscillator loss clears the low watchdog select bit.
// - In stop mode timer runs only in pseudo-stop on crystal clock.
// - Timer control always accessible; every write restarts the period.
// - Any timer select change, oscillator loss included, restarts the period.
// - Control bit 7 picks binary (0) or decimal (1) prescaling.
// - Bits 6..4 pick prescale; binary codes 001..111 give 2^10..2^16.
// - Bits 3..0 give modulus field plus one, multiplied with prescaler.
// - Binary prescale code 000 turns the timer off.
// - Decimal codes give bases 1000 through 200000 times modulus field plus one.
module ptcs_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock sources and system state
    input wire ptcs_pkg::ptcs_ticks_t source_ticks,
    input wire logic oscillator_up_status,
    input wire logic stop_mode_active,
    // Periodic timer
    output logic timeout_pulse,
    output logic timeout_flag,
    // Watchdog clocking
    output logic [1:0] watchdog_source,
    output logic watchdog_tick,
    output logic watchdog_restart
);

    // APB state
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pslverr_q;
    logic pslverr_d;
    logic setup_phase;
    logic write_taken;
    logic [7:0] reg_index;
    logic word_aligned;

    // Registers
    logic [7:0] clk_sel_q;
    logic [7:0] clk_sel_d;
    ptcs_pkg::ptcs_ctrl_t ctrl_q;
    logic timeout_flag_q;
    logic timeout_pulse_q;

    // Timer datapath
    logic [ptcs_pkg::PRESCALE_W-1:0] pre_cnt_q;
    logic [3:0] mod_cnt_q;
    logic [ptcs_pkg::PRESCALE_W-1:0] pre_limit;
    logic timer_off;
    logic timer_tick;
    logic count_en;
    logic timer_restart;
    logic period_end;
    logic wr_clk_sel;
    logic wr_ctrl;
    logic wr_status;

    // Watchdog
    logic [1:0] wd_source_q;
    logic [1:0] wd_source_d;
    logic wd_tick_q;
    logic wd_restart_q;
    logic wd_restart_d;

    assign setup_phase = psel && !penable && !pready_q;
    assign reg_index = paddr[9:2];
    assign word_aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign write_taken = psel && penable && pready_q && pwrite
        && !pslverr_q && pstrb[0];
    assign wr_clk_sel = write_taken
        && (reg_index == ptcs_pkg::IDX_CLK_SEL);
    assign wr_ctrl = write_taken
        && (reg_index == ptcs_pkg::IDX_TIMER_CTRL);
    assign wr_status = write_taken
        && (reg_index == ptcs_pkg::IDX_STATUS);

    // Address decode and read data, captured in the setup cycle
    always_comb begin
        prdata_d = 32'h0000_0000;
        pslverr_d = 1'b0;
        if (!word_aligned) begin
            pslverr_d = 1'b1;
        end else begin
            case (reg_index)
                ptcs_pkg::IDX_CLK_SEL: begin
                    prdata_d[7:0] = clk_sel_q;
                end
                ptcs_pkg::IDX_TIMER_CTRL: begin
                    prdata_d[7:0] = ctrl_q;
                end
                ptcs_pkg::IDX_STATUS: begin
                    prdata_d[ptcs_pkg::ST_OSC_UP_BIT] = oscillator_up_status;
                    prdata_d[ptcs_pkg::ST_FLAG_BIT] = timeout_flag_q;
                    prdata_d[ptcs_pkg::ST_RUNNING_BIT] = !timer_off;
                    prdata_d[ptcs_pkg::ST_TIMER_SEL_BIT] =
                        clk_sel_q[ptcs_pkg::CS_TIMER_SEL_BIT];
                end
                ptcs_pkg::IDX_COUNT: begin
                    prdata_d[ptcs_pkg::PRESCALE_W+3:0] = {pre_cnt_q, mod_cnt_q};
                end
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
    end

    // One-cycle answer: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup_phase;
            if (setup_phase) begin
                pslverr_q <= pslverr_d;
                prdata_q <= pwrite ? 32'h0000_0000 : prdata_d;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // Clock source select: crystal selects only stick with oscillator up
    always_comb begin
        clk_sel_d = clk_sel_q;
        if (wr_clk_sel) begin
            clk_sel_d = 8'h00;
            clk_sel_d[ptcs_pkg::CS_PSEUDO_STOP_BIT] =
                pwdata[ptcs_pkg::CS_PSEUDO_STOP_BIT];
            clk_sel_d[ptcs_pkg::CS_WD_SEL_HIGH_BIT] =
                pwdata[ptcs_pkg::CS_WD_SEL_HIGH_BIT];
            clk_sel_d[ptcs_pkg::CS_TIMER_SEL_BIT] =
                pwdata[ptcs_pkg::CS_TIMER_SEL_BIT];
            clk_sel_d[ptcs_pkg::CS_WD_SEL_LOW_BIT] =
                pwdata[ptcs_pkg::CS_WD_SEL_LOW_BIT];
        end
        if (!oscillator_up_status) begin
            clk_sel_d[ptcs_pkg::CS_TIMER_SEL_BIT] = 1'b0;
            clk_sel_d[ptcs_pkg::CS_WD_SEL_LOW_BIT] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sel_q <= ptcs_pkg::CLK_SEL_RESET;
        end else begin
            clk_sel_q <= clk_sel_d;
        end
    end

    // Timer control register, all-zero reset leaves the timer off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= ptcs_pkg::TIMER_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata[7:0];
        end
    end

    // Prescale limit from mode and code
    always_comb begin
        pre_limit = '0;
        if (ctrl_q.decimal_divider_select) begin
            case (ctrl_q.prescale)
                3'h0: pre_limit = ptcs_pkg::DEC_BASE_0 - 1'b1;
                3'h1: pre_limit = ptcs_pkg::DEC_BASE_1 - 1'b1;
                3'h2: pre_limit = ptcs_pkg::DEC_BASE_2 - 1'b1;
                3'h3: pre_limit = ptcs_pkg::DEC_BASE_3 - 1'b1;
                3'h4: pre_limit = ptcs_pkg::DEC_BASE_4 - 1'b1;
                3'h5: pre_limit = ptcs_pkg::DEC_BASE_5 - 1'b1;
                3'h6: pre_limit = ptcs_pkg::DEC_BASE_6 - 1'b1;
                default: pre_limit = ptcs_pkg::DEC_BASE_7 - 1'b1;
            endcase
        end else begin
            pre_limit = ({{(ptcs_pkg::PRESCALE_W-1){1'b0}}, 1'b1}
                << (ptcs_pkg::BIN_SHIFT_BASE + 32'(ctrl_q.prescale)))
                - 1'b1;
        end
    end

    assign timer_off = !ctrl_q.decimal_divider_select
        && (ctrl_q.prescale == ptcs_pkg::PRESCALE_OFF_CODE);

    // Source tick for the timer
    assign timer_tick = clk_sel_q[ptcs_pkg::CS_TIMER_SEL_BIT]
        ? source_ticks.crystal : source_ticks.trimmed_rc;

    // Halt in stop mode unless pseudo-stop on the crystal
    assign count_en = timer_tick && !timer_off && (!stop_mode_active
        || (clk_sel_q[ptcs_pkg::CS_PSEUDO_STOP_BIT]
        && clk_sel_q[ptcs_pkg::CS_TIMER_SEL_BIT]));

    // Write to control or any change of the timer select, loss included
    assign timer_restart = wr_ctrl
        || (clk_sel_d[ptcs_pkg::CS_TIMER_SEL_BIT]
        != clk_sel_q[ptcs_pkg::CS_TIMER_SEL_BIT]);

    assign period_end = count_en && !timer_restart
        && (pre_cnt_q == pre_limit)
        && (mod_cnt_q == ctrl_q.modulus);

    // Prescale and modulus counters; counts held, not cleared, when halted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_q <= '0;
            mod_cnt_q <= 4'h0;
        end else if (timer_restart) begin
            pre_cnt_q <= '0;
            mod_cnt_q <= 4'h0;
        end else if (count_en) begin
            if (pre_cnt_q >= pre_limit) begin
                pre_cnt_q <= '0;
                if (mod_cnt_q >= ctrl_q.modulus) begin
                    mod_cnt_q <= 4'h0;
                end else begin
                    mod_cnt_q <= mod_cnt_q + 4'h1;
                end
            end else begin
                pre_cnt_q <= pre_cnt_q + 1'b1;
            end
        end
    end

    // Timeout pulse and sticky flag; setting wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_pulse_q <= 1'b0;
            timeout_flag_q <= 1'b0;
        end else begin
            timeout_pulse_q <= period_end;
            if (period_end) begin
                timeout_flag_q <= 1'b1;
            end else if (wr_status && pwdata[ptcs_pkg::ST_FLAG_BIT]) begin
                timeout_flag_q <= 1'b0;
            end
        end
    end

    // Watchdog source and restart
    always_comb begin
        if (clk_sel_d[ptcs_pkg::CS_WD_SEL_HIGH_BIT]) begin
            wd_source_d = ptcs_pkg::WD_SRC_ALWAYS_ON;
        end else if (clk_sel_d[ptcs_pkg::CS_WD_SEL_LOW_BIT]) begin
            wd_source_d = ptcs_pkg::WD_SRC_CRYSTAL;
        end else begin
            wd_source_d = ptcs_pkg::WD_SRC_RC;
        end
        wd_restart_d = (clk_sel_d[ptcs_pkg::CS_WD_SEL_HIGH_BIT]
            != clk_sel_q[ptcs_pkg::CS_WD_SEL_HIGH_BIT])
            || (!clk_sel_q[ptcs_pkg::CS_WD_SEL_HIGH_BIT]
            && !clk_sel_d[ptcs_pkg::CS_WD_SEL_HIGH_BIT]
            && (clk_sel_d[ptcs_pkg::CS_WD_SEL_LOW_BIT]
            != clk_sel_q[ptcs_pkg::CS_WD_SEL_LOW_BIT]));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_source_q <= ptcs_pkg::WD_SRC_RC;
            wd_restart_q <= 1'b0;
        end else begin
            wd_source_q <= wd_source_d;
            wd_restart_q <= wd_restart_d;
        end
    end

    // Watchdog tick follows the registered source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_tick_q <= 1'b0;
        end else begin
            case (wd_source_q)
                ptcs_pkg::WD_SRC_CRYSTAL: wd_tick_q <= source_ticks.crystal;
                ptcs_pkg::WD_SRC_ALWAYS_ON: wd_tick_q <= source_ticks.always_on;
                default: wd_tick_q <= source_ticks.trimmed_rc;
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign timeout_pulse = timeout_pulse_q;
    assign timeout_flag = timeout_flag_q;
    assign watchdog_source = wd_source_q;
    assign watchdog_tick = wd_tick_q;
    assign watchdog_restart = wd_restart_q;

endmodule

// [bench/ptcs_checker.sv]
`timescale 1ns/1ps
module ptcs_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sources and state
    input wire ptcs_pkg::ptcs_ticks_t source_ticks,
    input wire logic oscillator_up_status,
    input wire logic stop_mode_active,
    // Timer and watchdog
    input wire logic timeout_pulse,
    input wire logic timeout_flag,
    input wire logic [1:0] watchdog_source,
    input wire logic watchdog_tick,
    input wire logic watchdog_restart
);
    logic [15:0] gap_q;
    logic clr;
    assign clr = psel && penable && pwrite && pstrb[0] && pwdata[1]
        && paddr == 12'h040;
    // Cycles since the last period end, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 16'hFFFF;
        end else if (timeout_pulse) begin
            gap_q <= 16'h0000;
        end else if (gap_q != 16'hFFFF) begin
            gap_q <= gap_q + 16'h0001;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pulse_sets_flag: assert property (timeout_pulse |-> timeout_flag)
        else $error("pulse without flag");
    a_pulse_single: assert property (timeout_pulse |=> !timeout_pulse)
        else $error("pulse too long");
    a_period_floor: assert property (timeout_pulse |-> gap_q >= 16'h03E7)
        else $error("period too short");
    a_flag_sticky: assert property (timeout_flag && !clr |=> timeout_flag)
        else $error("flag lost");
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no answer");
    a_no_osc_crystal: assert property (!oscillator_up_status [*2] |->
        watchdog_source != ptcs_pkg::WD_SRC_CRYSTAL) else $error("crystal kept");
    a_src_restart: assert property ($changed(watchdog_source) |->
        ##[0:1] watchdog_restart) else $error("no restart");
    a_stop_halts: assert property ((stop_mode_active
        && !oscillator_up_status) [*3] |-> !timeout_pulse)
        else $error("pulse in stop");
    c_pulse: cover property (timeout_pulse);
    c_restart: cover property (watchdog_restart);
    c_error: cover property (pslverr);
endmodule

bind ptcs_top ptcs_checker i_chk (.*);

// [bench/periodic_timer_clock_select_tb.sv]
`timescale 1ns/1ps
module periodic_timer_clock_select_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    ptcs_pkg::ptcs_ticks_t source_ticks;
    logic oscillator_up_status, stop_mode_active;
    logic timeout_pulse, timeout_flag, watchdog_tick, watchdog_restart;
    logic [1:0] watchdog_source;
    logic [7:0] cyc;
    int errors, compares;

    ptcs_top i_dut (.*);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Sources tick every cycle, every second and every fourth cycle
    always @(posedge pclk) begin
        cyc <= cyc + 8'h01;
        source_ticks <= {cyc[1:0] == 2'h0, cyc[0], 1'b1};
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
            input logic [7:0] d, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 8'h00, r, e);
    endtask

    task automatic wpulse(input int lim, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (timeout_pulse !== 1'b1 && n < lim);
    endtask

    task automatic meas(input logic [7:0] c, input int t);
        int n;
        wr(12'h02C, c);
        wpulse(300000, n);
        wpulse(300000, n);
        chk(n, t);
    endtask

    task automatic nore(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (3) begin
            @(posedge pclk);
            seen = seen | (watchdog_restart === 1'b1);
        end
        chk(32'(seen), 32'(exp));
    endtask

    // Counts watchdog ticks over 16 cycles of a settled source
    task automatic ticks(input logic [31:0] exp);
        logic [31:0] cnt;
        cnt = 32'h0000_0000;
        repeat (16) begin
            @(posedge pclk);
            cnt = cnt + 32'(watchdog_tick === 1'b1);
        end
        chk(cnt, exp);
    endtask

    // Address zero stands for a loss of the oscillator
    task automatic restart_chk(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        repeat (300) @(posedge pclk);
        if (a == 12'h000)
            oscillator_up_status <= 1'b0;
        else
            wr(a, d);
        rd(12'h044, r);
        chk(32'(r[21:4] < 18'h0_0004), 32'h0000_0001);
    endtask

    task automatic s_regs;
        logic [31:0] r;
        logic e;
        rd(12'h024, r);
        chk(r, 32'h0000_0000);
        rd(12'h02C, r);
        chk(r, 32'h0000_0000);
        rd(12'h040, r);
        chk(r, 32'h0000_0001);
        apb(1'b1, 12'h030, 8'h55, r, e);
        chk(32'(e), 32'h0000_0001);
        wr(12'h02C, 8'hA5);
        rd(12'h02C, r);
        chk(r, 32'h0000_00A5);
    endtask

    task automatic s_select;
        logic [31:0] r;
        @(posedge pclk) oscillator_up_status <= 1'b0;
        wr(12'h024, 8'h13);
        rd(12'h024, r);
        chk(r, 32'h0000_0010);
        chk(32'(watchdog_source), 32'(ptcs_pkg::WD_SRC_ALWAYS_ON));
        ticks(32'h0000_0004);
        @(posedge pclk) oscillator_up_status <= 1'b1;
        wr(12'h024, 8'h13);
        rd(12'h024, r);
        chk(r, 32'h0000_0013);
        wr(12'h024, 8'h12);
        nore(1'b0);
        chk(32'(watchdog_source), 32'(ptcs_pkg::WD_SRC_ALWAYS_ON));
        wr(12'h024, 8'h02);
        wr(12'h024, 8'h03);
        nore(1'b1);
        chk(32'(watchdog_source), 32'(ptcs_pkg::WD_SRC_CRYSTAL));
        ticks(32'h0000_0008);
        @(posedge pclk) oscillator_up_status <= 1'b0;
        repeat (3) @(posedge pclk);
        rd(12'h024, r);
        chk(r, 32'h0000_0000);
        chk(32'(watchdog_source), 32'(ptcs_pkg::WD_SRC_RC));
        ticks(32'h0000_0010);
        @(posedge pclk) oscillator_up_status <= 1'b1;
    endtask

    task automatic s_period;
        int n;
        meas(8'h10, 1024);
        meas(8'h11, 2048);
        meas(8'h80, 1000);
        meas(8'h92, 6000);
        wr(12'h02C, 8'h05);
        wpulse(5000, n);
        chk(n, 5000);
        wr(12'h024, 8'h02);
        meas(8'h10, 2048);
        restart_chk(12'h024, 8'h00);
        restart_chk(12'h02C, 8'h10);
        wr(12'h024, 8'h02);
        restart_chk(12'h000, 8'h00);
        @(posedge pclk) oscillator_up_status <= 1'b1;
    endtask

    task automatic s_stop;
        logic [31:0] a, b;
        for (int i = 0; i < 2; i++) begin
            wr(12'h024, i == 0 ? 8'h00 : 8'h42);
            // First pass also loses the oscillator while stopped
            @(posedge pclk) {stop_mode_active, oscillator_up_status} <=
                {1'b1, i == 1};
            rd(12'h044, a);
            repeat (20) @(posedge pclk);
            rd(12'h044, b);
            chk(32'(b !== a), 32'(i));
            @(posedge pclk) {stop_mode_active, oscillator_up_status} <= 2'h1;
        end
        chk(32'(timeout_flag), 32'h0000_0001);
        wr(12'h040, 8'h02);
        @(posedge pclk);
        chk(32'(timeout_flag), 32'h0000_0000);
    endtask

    task automatic summarize;
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, stop_mode_active} = 5'h00;
        {paddr, pwdata, cyc, source_ticks} = '0;
        pstrb = 4'hF;
        oscillator_up_status = 1'b1;
        errors = 0;
        compares = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_select();
        s_period();
        s_stop();
        summarize();
    end

    initial begin
        #1_000_000;
        errors++;
        summarize();
    end
endmodule
